//--- logic/cdps_defs.svh
/*
 * Constants of the card interrogation and power switch controller:
 * timing, control word bit positions, register offsets and fields.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CDPS_DEFS_SVH
`define CDPS_DEFS_SVH

// timing
`define CLK_HZ 125000000
`define OSC_HZ 16000
`define SETTLE_TICKS 3'h4
`define PROBE_WAIT 3'h1
`define SH_TOP 4'ha
`define SH_LATCH 5'h16
`define SH_END 5'h17
`define SYNC_IDLE 4'hf

// control word bits toward the switch
`define D0 0
`define D1 1
`define D2 2
`define D3 3
`define D8 8
`define D9 9

// register byte offsets
`define ADDR_STATUS 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_EVENT 8'h08
`define ADDR_MASK 8'h0c

// control register fields
`define CTL_TYPE 0
`define CTL_VPP_LSB 1
`define CTL_VCC_LSB 4
`define CTL_APPLY 8

// event bits
`define EV_INSERT 0
`define EV_REMOVE 1
`define EV_DONE 2
`define EV_APPLIED 3
`define EV_REFUSED 4

// status register fields
`define ST_BUSY 3
`define ST_F5 4
`define ST_LOW_VOLT 5
`define ST_EXTRA_VOLT 6
`define ST_FY 7
`define ST_CORE 8
`define ST_SHIFTING 9
`define ST_VCC_LSB 10
`define ST_VPP_LSB 12
`define ST_SWITCH_SHUTDOWN_N_N 15

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/cdps_pkg.sv
/*
 * Types of the card interrogation and power switch controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cdps_pkg;
  typedef enum logic [2:0] {S_EMPTY, S_SETTLE, S_PROBE_A, S_PROBE_B,
    S_CLASSIFY, S_PRESENT} intr_state_t;
  typedef enum logic [2:0] {CLS_NONE, CLS_16BIT, CLS_CARDBUS, CLS_CUSTOM,
    CLS_RESERVED} card_class_t;
  typedef enum logic [2:0] {VPP_0V, VPP_3V3, VPP_5V, VPP_12V, VPP_1V8,
    VPP_HIZ} vpp_out_t;
  typedef enum logic [1:0] {VCC_0V, VCC_3V3, VCC_5V, VCC_HIZ} vcc_out_t;
  typedef struct packed {
    logic [12:0] tick_cnt;
    logic tick;
    logic [3:0] sync1;
    logic [3:0] sync2;
    intr_state_t st;
    logic [2:0] tcnt;
    logic [3:0] rel;
    logic [1:0] pa;
    logic [1:0] pb;
    card_class_t cls;
    logic f5;
    logic f3;
    logic fx;
    logic fy;
    logic core;
    logic [1:0] cd_drive;
    logic sw_type;
    logic [2:0] vpp_req;
    logic [1:0] vcc_req;
    logic want;
    logic pend;
    logic [10:0] word;
    logic [10:0] applied;
    logic shifting;
    logic [4:0] sh_cnt;
    logic ser_data;
    logic ser_clk;
    logic ser_latch;
    logic [4:0] ev;
    logic [4:0] mask;
    logic irq;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;
endpackage

//--- logic/card_detect_power_switch_ctl.sv
/*
 * Card interrogation and power switch control for one socket, with an
 * AXI4-Lite register slave and a level interrupt.
 * Assumes card contacts pulled up outside, a three-wire power switch on
 * sw_data/sw_clock/sw_latch, and one 125 MHz clock.
 */
`include "cdps_defs.svh"

module card_detect_power_switch_ctl #(
  parameter int TICK_CYCLES = `CLK_HZ / `OSC_HZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // card contacts, detects are open-drain
  input wire logic card_detect_a_in,
  output logic card_detect_a_out,
  output logic card_detect_a_oe,
  input wire logic card_detect_b_in,
  output logic card_detect_b_out,
  output logic card_detect_b_oe,
  input wire logic volt_sense_a,
  input wire logic volt_sense_b,
  // power switch serial link
  output logic sw_data,
  output logic sw_clock,
  output logic sw_latch,
  // interrupt
  output logic irq
);

  cdps_pkg::ctl_state_t s;
  cdps_pkg::ctl_state_t n;
  logic lv_flag;
  logic xv_flag;
  logic vcc_ok;
  logic vpp_ok;
  logic allow;
  cdps_pkg::vpp_out_t vpp_out;
  cdps_pkg::vcc_out_t vcc_out;
  cdps_pkg::vpp_out_t vpp_want;
  logic [31:0] status;
  logic [10:0] on_word;

  function automatic cdps_pkg::vpp_out_t vpp_dec(input logic t,
      input logic switch_shutdown_n_n, input logic [2:0] b);
    cdps_pkg::vpp_out_t v;
    v = cdps_pkg::VPP_HIZ;
    if (!switch_shutdown_n_n) begin
      v = cdps_pkg::VPP_HIZ;
    end else if (b[2:1] == 2'h0) begin
      v = cdps_pkg::VPP_0V;
    end else if (b[2:1] == 2'h1) begin
      v = b[0] ? cdps_pkg::VPP_5V : cdps_pkg::VPP_3V3;
    end else if (!t) begin
      v = (b == 3'h7) ? cdps_pkg::VPP_1V8 : cdps_pkg::VPP_HIZ;
    end else begin
      v = b[1] ? cdps_pkg::VPP_HIZ : cdps_pkg::VPP_12V;
    end
    return v;
  endfunction

  function automatic cdps_pkg::vcc_out_t vcc_dec(input logic switch_shutdown_n_n,
      input logic [1:0] b);
    cdps_pkg::vcc_out_t v;
    v = cdps_pkg::VCC_HIZ;
    if (!switch_shutdown_n_n) begin
      v = cdps_pkg::VCC_HIZ;
    end else begin
      case (b)
        2'h1: v = cdps_pkg::VCC_3V3;
        2'h2: v = cdps_pkg::VCC_5V;
        default: v = cdps_pkg::VCC_0V;
      endcase
    end
    return v;
  endfunction

  // reported flags follow the switch type for a 1.8 V core card
  assign lv_flag = s.f3 | (s.core & !s.sw_type);
  assign xv_flag = s.fx | (s.core & s.sw_type);
  assign vpp_out = vpp_dec(s.sw_type, s.applied[`D8],
    {s.applied[`D0], s.applied[`D1], s.applied[`D9]});
  assign vcc_out = vcc_dec(s.applied[`D8],
    {s.applied[`D3], s.applied[`D2]});
  assign vpp_want = vpp_dec(s.sw_type, 1'b1, s.vpp_req);

  // request must fit the decoded card
  assign vcc_ok = (s.vcc_req == 2'h1) ? (s.f3 | s.core) :
    (s.vcc_req == 2'h2) ? s.f5 : 1'b1;
  always_comb begin
    case (vpp_want)
      cdps_pkg::VPP_3V3: vpp_ok = s.f3 | s.core;
      cdps_pkg::VPP_5V: vpp_ok = s.f5;
      cdps_pkg::VPP_12V: vpp_ok = s.cls == cdps_pkg::CLS_16BIT;
      cdps_pkg::VPP_1V8: vpp_ok = s.core;
      default: vpp_ok = 1'b1;
    endcase
  end
  assign allow = s.want && s.st == cdps_pkg::S_PRESENT && vcc_ok && vpp_ok;

  assign on_word = (11'h1 << `D0) & {11{s.vpp_req[2]}}
    | (11'h1 << `D1) & {11{s.vpp_req[1]}}
    | (11'h1 << `D9) & {11{s.vpp_req[0]}}
    | (11'h1 << `D3) & {11{s.vcc_req[1]}}
    | (11'h1 << `D2) & {11{s.vcc_req[0]}}
    | (11'h1 << `D8);

  always_comb begin
    status = 32'h0;
    status[2:0] = s.cls;
    status[`ST_BUSY] = s.st != cdps_pkg::S_EMPTY &&
      s.st != cdps_pkg::S_PRESENT;
    status[`ST_F5] = s.f5;
    status[`ST_LOW_VOLT] = lv_flag;
    status[`ST_EXTRA_VOLT] = xv_flag;
    status[`ST_FY] = s.fy;
    status[`ST_CORE] = s.core;
    status[`ST_SHIFTING] = s.shifting;
    status[`ST_VCC_LSB +: 2] = vcc_out;
    status[`ST_VPP_LSB +: 3] = vpp_out;
    status[`ST_SWITCH_SHUTDOWN_N_N] = s.applied[`D8];
  end

  always_comb begin
    logic [4:0] evset;
    logic [4:0] evclr;
    logic [31:0] wm;
    logic [31:0] cw;
    logic ta1;
    logic ta2;
    logic tb1;
    logic tb2;
    evset = 5'h0;
    evclr = 5'h0;
    wm = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}},
      {8{s.wstrb[0]}}};
    cw = (32'(s.sw_type) << `CTL_TYPE) | (32'(s.vpp_req) << `CTL_VPP_LSB)
      | (32'(s.vcc_req) << `CTL_VCC_LSB);
    cw = (cw & ~wm) | (s.wdata & wm);
    ta1 = s.rel[0] & s.rel[2] & !s.pa[0];
    ta2 = s.rel[0] & s.rel[3] & !s.pa[1];
    tb1 = s.rel[1] & s.rel[2] & !s.pb[0];
    tb2 = s.rel[1] & s.rel[3] & !s.pb[1];
    n = s;

    // internal slow tick
    if (s.tick_cnt == 13'(TICK_CYCLES - 1)) begin
      n.tick_cnt = 13'h0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 13'h1;
      n.tick = 1'b0;
    end
    n.sync1 = {volt_sense_b, volt_sense_a, card_detect_b_in,
      card_detect_a_in};
    n.sync2 = s.sync1;

    // register writes
    if (awvalid && !s.aw_got && !s.bvalid) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && !s.w_got && !s.bvalid) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (s.awaddr)
        `ADDR_STATUS: ;
        `ADDR_CTRL: begin
          n.sw_type = cw[`CTL_TYPE];
          n.vpp_req = cw[`CTL_VPP_LSB +: 3];
          n.vcc_req = cw[`CTL_VCC_LSB +: 2];
          if (s.wdata[`CTL_APPLY] && s.wstrb[1]) begin
            n.want = 1'b1;
            n.pend = 1'b1;
          end
        end
        `ADDR_EVENT: evclr = s.wdata[4:0] & {5{s.wstrb[0]}};
        `ADDR_MASK: begin
          if (s.wstrb[0]) begin
            n.mask = s.wdata[4:0];
          end
        end
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // register reads
    if (arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      case (araddr)
        `ADDR_STATUS: n.rdata = status;
        `ADDR_CTRL: n.rdata = (32'(s.sw_type) << `CTL_TYPE)
          | (32'(s.vpp_req) << `CTL_VPP_LSB)
          | (32'(s.vcc_req) << `CTL_VCC_LSB);
        `ADDR_EVENT: n.rdata = 32'(s.ev);
        `ADDR_MASK: n.rdata = 32'(s.mask);
        default: begin
          n.rdata = 32'h0;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // interrogation
    case (s.st)
      cdps_pkg::S_EMPTY: begin
        n.cd_drive = 2'h0;
        if (!s.sync2[0] || !s.sync2[1]) begin
          n.st = cdps_pkg::S_SETTLE;
          n.tcnt = 3'h0;
          evset[`EV_INSERT] = 1'b1;
        end
      end
      cdps_pkg::S_SETTLE: begin
        if (s.sync2[1:0] == 2'h3) begin
          n.st = cdps_pkg::S_EMPTY;
        end else if (s.tick) begin
          if (s.tcnt == `SETTLE_TICKS - 3'h1) begin
            n.rel = s.sync2;
            n.cd_drive = 2'h1;
            n.tcnt = 3'h0;
            n.st = cdps_pkg::S_PROBE_A;
          end else begin
            n.tcnt = s.tcnt + 3'h1;
          end
        end
      end
      cdps_pkg::S_PROBE_A: begin
        if (s.tick) begin
          if (s.tcnt != `PROBE_WAIT) begin
            n.tcnt = `PROBE_WAIT;
          end else begin
            n.pa = s.sync2[3:2];
            n.cd_drive = 2'h2;
            n.tcnt = 3'h0;
            n.st = cdps_pkg::S_PROBE_B;
          end
        end
      end
      cdps_pkg::S_PROBE_B: begin
        if (s.tick) begin
          if (s.tcnt != `PROBE_WAIT) begin
            n.tcnt = `PROBE_WAIT;
          end else begin
            n.pb = s.sync2[3:2];
            n.cd_drive = 2'h0;
            n.st = cdps_pkg::S_CLASSIFY;
          end
        end
      end
      cdps_pkg::S_CLASSIFY: begin
        n.st = cdps_pkg::S_PRESENT;
        evset[`EV_DONE] = 1'b1;
        {n.f5, n.f3, n.fx, n.fy, n.core} = 5'h0;
        n.cls = cdps_pkg::CLS_CARDBUS;
        if (!s.rel[0] && !s.rel[1]) begin
          n.cls = cdps_pkg::CLS_16BIT;
          n.f5 = !(!s.rel[3] && s.rel[2]);
          n.f3 = !s.rel[2];
          n.fx = !s.rel[3];
        end else if (ta1) begin
          if (s.rel[3]) begin
            n.f3 = 1'b1;
          end else begin
            n.cls = cdps_pkg::CLS_CUSTOM;
          end
        end else if (ta2) begin
          if (s.rel[2]) begin
            {n.fx, n.fy} = 2'h3;
          end else begin
            n.cls = cdps_pkg::CLS_RESERVED;
          end
        end else if (tb2) begin
          if (s.rel[2]) begin
            n.core = 1'b1;
          end else begin
            {n.f3, n.fx} = 2'h3;
          end
        end else if (tb1) begin
          if (s.rel[3]) begin
            n.fy = 1'b1;
          end else begin
            {n.f3, n.fx, n.fy} = 3'h7;
          end
        end else begin
          n.cls = cdps_pkg::CLS_RESERVED;
        end
      end
      cdps_pkg::S_PRESENT: begin
        if (s.sync2[1:0] == 2'h3) begin
          n.st = cdps_pkg::S_EMPTY;
          n.cls = cdps_pkg::CLS_NONE;
          {n.f5, n.f3, n.fx, n.fy, n.core} = 5'h0;
          n.want = 1'b0;
          n.pend = 1'b1;
          evset[`EV_REMOVE] = 1'b1;
        end
      end
      default: n.st = cdps_pkg::S_EMPTY;
    endcase

    // serial word to the switch
    if (!s.shifting) begin
      if (s.pend && !(s.st == cdps_pkg::S_PRESENT &&
          s.sync2[1:0] == 2'h3)) begin
        n.pend = 1'b0;
        n.shifting = 1'b1;
        n.sh_cnt = 5'h0;
        n.word = allow ? on_word : 11'h0;
        evset[`EV_REFUSED] = s.want && !allow;
        n.want = 1'b0;
      end
    end else if (s.tick) begin
      n.sh_cnt = s.sh_cnt + 5'h1;
      if (s.sh_cnt < `SH_LATCH) begin
        n.ser_clk = s.sh_cnt[0];
        n.ser_data = s.word[`SH_TOP - s.sh_cnt[4:1]];
      end else if (s.sh_cnt == `SH_LATCH) begin
        n.ser_clk = 1'b0;
        n.ser_latch = 1'b1;
      end else begin
        n.ser_latch = 1'b0;
        n.shifting = 1'b0;
        n.applied = s.word;
        evset[`EV_APPLIED] = 1'b1;
      end
    end

    n.ev = (s.ev & ~evclr) | evset;
    n.irq = |(n.ev & n.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.pend <= 1'b1;
      // contacts read as open, so no false insertion after reset
      s.sync1 <= `SYNC_IDLE;
      s.sync2 <= `SYNC_IDLE;
    end else begin
      s <= n;
    end
  end

  assign awready = !s.aw_got && !s.bvalid;
  assign wready = !s.w_got && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign card_detect_a_out = 1'b0;
  assign card_detect_b_out = 1'b0;
  assign card_detect_a_oe = s.cd_drive[0];
  assign card_detect_b_oe = s.cd_drive[1];
  assign sw_data = s.ser_data;
  assign sw_clock = s.ser_clk;
  assign sw_latch = s.ser_latch;
  assign irq = s.irq;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_insert;
    s.st == cdps_pkg::S_EMPTY && !s.sync2[0] |=>
      s.st == cdps_pkg::S_SETTLE && s.ev[`EV_INSERT];
  endproperty
  a_insert: assert property (p_insert) else $error("insert missed");

  property p_probe_drive;
    s.st == cdps_pkg::S_PROBE_A |-> card_detect_a_oe && !card_detect_b_oe;
  endproperty
  a_probe_drive: assert property (p_probe_drive)
    else $error("wrong detect driven");

  property p_lv_type0;
    s.core && !s.sw_type |-> status[`ST_LOW_VOLT] && !status[`ST_EXTRA_VOLT];
  endproperty
  a_lv_type0: assert property (p_lv_type0)
    else $error("core card flag wrong for type 0");

  property p_xv_type1;
    s.core && s.sw_type && !s.fx |->
      status[`ST_EXTRA_VOLT] && !status[`ST_LOW_VOLT];
  endproperty
  a_xv_type1: assert property (p_xv_type1)
    else $error("core card flag wrong for type 1");

  property p_reset_type;
    $rose(aresetn) |-> !s.sw_type && !sw_latch;
  endproperty
  a_reset_type: assert property (p_reset_type)
    else $error("switch type not 0 after reset");

  property p_switch_shutdown_n_hiz;
    !s.applied[`D8] |->
      vpp_out == cdps_pkg::VPP_HIZ && vcc_out == cdps_pkg::VCC_HIZ;
  endproperty
  a_switch_shutdown_n_hiz: assert property (p_switch_shutdown_n_hiz)
    else $error("outputs not Hi-Z in shutdown");

  property p_latch_after_word;
    $rose(sw_latch) |-> s.sh_cnt == `SH_END && !sw_clock;
  endproperty
  a_latch_after_word: assert property (p_latch_after_word)
    else $error("latch before the word ended");

  property p_on_only_present;
    $rose(s.shifting) && s.word[`D8] |->
      $past(s.st) == cdps_pkg::S_PRESENT;
  endproperty
  a_on_only_present: assert property (p_on_only_present)
    else $error("supply enabled without a decoded card");

  property p_tick_single;
    s.tick |=> !s.tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("tick longer than one cycle");

endmodule

//--- verification/card_switch_model.sv
/*
 * Far side of the socket: card contacts and a three-wire power switch.
 * Assumes the bench picks the card pattern and the switch type.
 */
module card_switch_model (
  // pattern: 0 ground, 1 open, 2 tied to sense a, 3 tied to sense b
  input wire logic [1:0] mode_a,
  input wire logic [1:0] mode_b,
  input wire logic open_a,
  input wire logic open_b,
  // socket side of the contacts
  input wire logic det_a_out,
  input wire logic det_a_oe,
  input wire logic det_b_out,
  input wire logic det_b_oe,
  output logic det_a,
  output logic det_b,
  output logic sense_a,
  output logic sense_b,
  // switch link and supply outputs
  input wire logic type_sel,
  input wire logic sdata,
  input wire logic sclk,
  input wire logic slatch,
  output logic [10:0] word,
  output int latches,
  output cdps_pkg::vpp_out_t vpp,
  output cdps_pkg::vcc_out_t vcc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] sr;

  // pulled up, low where grounded or driven by the socket
  assign det_a = det_a_oe ? det_a_out : (mode_a != 2'h0);
  assign det_b = det_b_oe ? det_b_out : (mode_b != 2'h0);
  assign sense_a = (mode_a == 2'h2) ? det_a :
    (mode_b == 2'h2) ? det_b : open_a;
  assign sense_b = (mode_a == 2'h3) ? det_a :
    (mode_b == 2'h3) ? det_b : open_b;

  // stale value is not an off word
  initial begin
    sr = 11'h7ff;
    word = 11'h7ff;
    latches = 0;
  end

  always @(posedge sclk) begin
    sr <= {sr[9:0], sdata};
  end

  always @(posedge slatch) begin
    word <= sr;
    latches <= latches + 1;
  end

  always_comb begin
    vcc = cdps_pkg::VCC_0V;
    vpp = cdps_pkg::VPP_HIZ;
    if (!word[8]) begin
      vcc = cdps_pkg::VCC_HIZ;
    end else begin
      if ({word[3], word[2]} == 2'h1) vcc = cdps_pkg::VCC_3V3;
      if ({word[3], word[2]} == 2'h2) vcc = cdps_pkg::VCC_5V;
      case ({word[0], word[1]})
        2'h0: vpp = cdps_pkg::VPP_0V;
        2'h1: vpp = word[9] ? cdps_pkg::VPP_5V : cdps_pkg::VPP_3V3;
        2'h2: if (type_sel) vpp = cdps_pkg::VPP_12V;
        default: if (!type_sel && word[9]) vpp = cdps_pkg::VPP_1V8;
      endcase
    end
  end
endmodule

//--- verification/test_card_detect_power_switch_ctl.sv
/*
 * Self-checking bench of the card interrogation and switch controller.
 * Assumes the design, its package and the far-side model compiled first.
 */
`include "cdps_defs.svh"

module test_card_detect_power_switch_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] ma;
    logic [1:0] mb;
    logic oa;
    logic ob;
    logic t;
    logic [8:0] st;
  } card_t;
  // contact pattern, switch type, expected status bits 8:0
  localparam card_t CARDS [13] = '{
    '{2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 9'h011},
    '{2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 9'h031},
    '{2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 9'h071},
    '{2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 9'h041},
    '{2'h2, 2'h0, 1'b1, 1'b1, 1'b0, 9'h022},
    '{2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 9'h003},
    '{2'h3, 2'h0, 1'b1, 1'b1, 1'b0, 9'h0c2},
    '{2'h3, 2'h0, 1'b0, 1'b1, 1'b0, 9'h004},
    '{2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 9'h122},
    '{2'h0, 2'h3, 1'b1, 1'b1, 1'b1, 9'h142},
    '{2'h0, 2'h3, 1'b0, 1'b1, 1'b0, 9'h062},
    '{2'h0, 2'h2, 1'b1, 1'b1, 1'b0, 9'h082},
    '{2'h0, 2'h2, 1'b1, 1'b0, 1'b0, 9'h0e2}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic det_a, det_b, sense_a, sense_b, da_out, da_oe, db_out, db_oe;
  logic sw_data, sw_clock, sw_latch, irq;
  logic [1:0] mode_a = 2'h1;
  logic [1:0] mode_b = 2'h1;
  logic open_a = 1'b1;
  logic open_b = 1'b1;
  logic type_sel = 1'b0;
  logic [10:0] word;
  int latches;
  cdps_pkg::vpp_out_t vpp;
  cdps_pkg::vcc_out_t vcc;
  int err_total = 0;
  int n_compared = 0;

  card_detect_power_switch_ctl #(.TICK_CYCLES(4)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .card_detect_a_in(det_a), .card_detect_a_out(da_out),
    .card_detect_a_oe(da_oe), .card_detect_b_in(det_b),
    .card_detect_b_out(db_out), .card_detect_b_oe(db_oe),
    .volt_sense_a(sense_a), .volt_sense_b(sense_b),
    .sw_data(sw_data), .sw_clock(sw_clock), .sw_latch(sw_latch), .irq(irq));

  card_switch_model far_side (
    .mode_a(mode_a), .mode_b(mode_b), .open_a(open_a), .open_b(open_b),
    .det_a_out(da_out), .det_a_oe(da_oe), .det_b_out(db_out),
    .det_b_oe(db_oe), .det_a(det_a), .det_b(det_b), .sense_a(sense_a),
    .sense_b(sense_b), .type_sel(type_sel), .sdata(sw_data),
    .sclk(sw_clock), .slatch(sw_latch), .word(word), .latches(latches),
    .vpp(vpp), .vcc(vcc));

  always #4 aclk = ~aclk;

  task automatic test_done();
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_p;
    logic w_p;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p) && n++ < 200) begin
      @(posedge aclk);
      if (aw_p && awready) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid && n++ < 200);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready && n++ < 200);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid && n++ < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_ev(input int b);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = 32'h0;
    n = 0;
    while (d[b] !== 1'b1 && n++ < 400) axi_rd(`ADDR_EVENT, d, r);
    check(32'(d[b]), 32'h1);
  endtask

  task automatic set_card(input card_t c);
    mode_a <= c.ma;
    mode_b <= c.mb;
    open_a <= c.oa;
    open_b <= c.ob;
  endtask

  task automatic card_in(input int i);
    logic [31:0] d;
    logic [1:0] r;
    type_sel <= CARDS[i].t;
    axi_wr(`ADDR_CTRL, 32'(CARDS[i].t), r);
    set_card(CARDS[i]);
    wait_ev(`EV_DONE);
    axi_rd(`ADDR_STATUS, d, r);
    check(d & 32'h1ff, 32'(CARDS[i].st));
    check(32'(d[`ST_SWITCH_SHUTDOWN_N_N]), 32'h0);
    axi_wr(`ADDR_EVENT, 32'h1f, r);
  endtask

  task automatic card_out();
    logic [1:0] r;
    set_card('{2'h1, 2'h1, 1'b1, 1'b1, 1'b0, 9'h000});
    wait_ev(`EV_REMOVE);
    wait_ev(`EV_APPLIED);
    check(32'(word), 32'h0);
    axi_wr(`ADDR_EVENT, 32'h1f, r);
  endtask

  function automatic cdps_pkg::vpp_out_t vpp_exp(input logic t,
                                                 input logic [2:0] c);
    case (c[2:1])
      2'h0: return cdps_pkg::VPP_0V;
      2'h1: return c[0] ? cdps_pkg::VPP_5V : cdps_pkg::VPP_3V3;
      2'h2: return t ? cdps_pkg::VPP_12V : cdps_pkg::VPP_HIZ;
      default: return (!t && c[0]) ? cdps_pkg::VPP_1V8 : cdps_pkg::VPP_HIZ;
    endcase
  endfunction

  initial begin
    repeat (50000) @(posedge aclk);
    err_total++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] ctrl;
    logic [1:0] r;
    logic [1:0] v;
    logic [2:0] c;
    logic t;
    logic refused;
    logic [10:0] ew;
    cdps_pkg::vpp_out_t ep;
    cdps_pkg::vcc_out_t ec;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`ADDR_CTRL, d, r);
    check(d, 32'h0);
    axi_rd(`ADDR_MASK, d, r);
    check(d, 32'h0);
    wait_ev(`EV_APPLIED);
    check(32'(word), 32'h0);
    check(32'(latches), 32'h1);
    axi_rd(`ADDR_EVENT, d, r);
    check(d, 32'h1 << `EV_APPLIED);
    check(32'(irq), 32'h0);
    axi_wr(`ADDR_MASK, 32'h1 << `EV_APPLIED, r);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h1);
    axi_wr(`ADDR_EVENT, 32'h1f, r);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    axi_wr(`ADDR_MASK, 32'h0, r);
    axi_wr(8'h10, 32'h1, r);
    check(32'(r), 32'(`RESP_SLVERR));
    axi_rd(8'h10, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(`RESP_SLVERR));
    for (int i = 0; i < 13; i++) begin
      card_in(i);
      card_out();
    end
    // 16-bit card taking 5 V, 3.3 V and X.X V, every code of both types
    card_in(2);
    for (int k = 0; k < 16; k++) begin
      t = k[3];
      c = k[2:0];
      v = k[1:0];
      refused = !t && c == 3'h7;
      ew = refused ? 11'h0 : {1'b0, c[0], 1'b1, 4'h0, v, c[1], c[2]};
      ep = refused ? cdps_pkg::VPP_HIZ : vpp_exp(t, c);
      ec = refused ? cdps_pkg::VCC_HIZ : (v == 2'h1) ? cdps_pkg::VCC_3V3 :
        (v == 2'h2) ? cdps_pkg::VCC_5V : cdps_pkg::VCC_0V;
      ctrl = 32'(t) | 32'(c) << 1 | 32'(v) << 4;
      type_sel <= t;
      axi_wr(`ADDR_CTRL, ctrl | 32'h100, r);
      wait_ev(`EV_APPLIED);
      axi_rd(`ADDR_CTRL, d, r);
      check(d, ctrl);
      axi_rd(`ADDR_EVENT, d, r);
      check(32'(d[`EV_REFUSED]), 32'(refused));
      check(32'(word), 32'(ew));
      axi_rd(`ADDR_STATUS, d, r);
      check(32'(d[15:10]), 32'({ew[8], ep, ec}));
      check(32'({vpp, vcc}), 32'({ep, ec}));
      axi_wr(`ADDR_EVENT, 32'h1f, r);
    end
    card_out();
    test_done();
  end
endmodule
